/* bwm_breaker_wear_monitor.sv */
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module bwm_breaker_wear_monitor
   import bwm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [CUR_W-1:0]  phase_current_l1,
   input  wire logic [CUR_W-1:0]  phase_current_l2,
   input  wire logic [CUR_W-1:0]  phase_current_l3,
   input  wire logic [NRELAY-1:0] trip_relay,
   input  wire logic [31:0]       time_stamp,
   output logic      [1:0]        alarm_out,
   output logic      [1:0]        event_on,
   output logic      [1:0]        event_off,
   output logic                   irq
);
   // log2 in fixed point, 8 fraction bits, linear mantissa
   function automatic logic [LG_W-1:0] lg2(input logic [CNT_W-1:0] x);
      logic [4:0]       p;
      logic [CNT_W-1:0] s;
      p = 5'h00;
      for (int i = 0; i < CNT_W; i++)
         if (x[i])
            p = 5'(i);
      s = x << (5'h10 - p);
      return {p, s[15:8]};
   endfunction

   // inverse of lg2
   function automatic logic [CNT_W-1:0] exp2(input logic [LG_W-1:0] l);
      logic [24:0] m;
      m = {16'h0000, 1'b1, l[7:0]} << l[12:8];
      return m[24:8];
   endfunction

   logic [CUR_W-1:0] pt_cur_reg [NPTS];
   logic [CNT_W-1:0] pt_cnt_reg [NPTS];
   logic [CUR_W-1:0] cap_reg;
   logic [CUR_W-1:0] al_cur_reg [2];
   logic [CNT_W-1:0] al_lim_reg [2];
   logic [1:0]       sel_reg;
   logic [3:0]       even_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [31:0]      trip_ts_reg;
   logic [CUR_W-1:0] trip_i_reg [3];
   logic [CNT_W-1:0] cnt_reg [6];
   logic [LG_W-1:0]  lc_reg [5];
   logic [1:0]       alarm_reg;
   logic [1:0]       ev_on_reg;
   logic [1:0]       ev_off_reg;
   logic             relay_prev_reg;
   logic             trip_pend_reg;
   logic             clr_pend_reg;
   logic             mode_clr_reg;
   logic [2:0]       job_reg;
   logic [LG_W-1:0]  base_reg;
   logic [LG_W-1:0]  den_reg;
   logic [NUM_W-1:0] dnum_reg;
   logic [LG_W:0]    rem_reg;
   logic [5:0]       step_reg;
   logic [31:0]      prdata_reg;
   bwm_state_t       state_reg;

   // bus decode
   wire       wr_en  = psel & penable & pwrite;
   wire [5:0] widx   = paddr[7:2];
   wire       hit_lo = paddr < 8'h38;
   wire       hit_c  = (paddr >= OFS_CNT) & (paddr < 8'h58);
   wire       hit_pt = paddr >= OFS_CURVE;
   wire       hit    = (paddr[1:0] == 2'b00) & (hit_lo | hit_c | hit_pt);
   wire [2:0] pt_idx = paddr[5:3];
   wire       pt_hi  = paddr[2];
   wire [2:0] c_idx  = 3'(widx - 6'h10);
   wire [1:0] t_idx  = 2'(widx - 6'h0B);

   wire wr_ctrl = wr_en & hit & (paddr == OFS_CTRL);
   wire wr_cap  = wr_en & (paddr == OFS_CAP);
   wire wr_a1c  = wr_en & (paddr == OFS_AL1_CUR);
   wire wr_a1l  = wr_en & (paddr == OFS_AL1_LIM);
   wire wr_a2c  = wr_en & (paddr == OFS_AL2_CUR);
   wire wr_a2l  = wr_en & (paddr == OFS_AL2_LIM);
   wire wr_ien  = wr_en & (paddr == OFS_IRQ_EN);
   wire wr_iclr = wr_en & (paddr == OFS_IRQ_CLR);
   wire wr_pt   = wr_en & hit & hit_pt;

   // setting ranges applied on write
   wire [CUR_W-1:0] w_cur = (pwdata[15:0] > AL_CUR_MAX) ? AL_CUR_MAX
                            : pwdata[15:0];
   wire [CNT_W-1:0] w_lim = (pwdata[16:0] < LIM_MIN) ? LIM_MIN
                          : (pwdata[16:0] > LIM_MAX) ? LIM_MAX
                          : pwdata[16:0];

   // trip supervision
   wire relay_now = trip_relay[sel_reg];
   wire trip_rise = relay_now & ~relay_prev_reg;
   wire busy      = state_reg != BWM_IDLE;
   wire start     = (state_reg == BWM_IDLE) & (clr_pend_reg | trip_pend_reg);

   // point valid unless at or beyond capacity
   logic [NPTS-1:0] pt_ok;
   genvar gp;
   generate
      for (gp = 0; gp < NPTS; gp++)
      begin : g_ok
         assign pt_ok[gp] = pt_cur_reg[gp] < cap_reg;
      end
   endgenerate

   // current being evaluated
   wire [CUR_W-1:0] cur_sel = (job_reg == 3'h0) ? al_cur_reg[0]
                            : (job_reg == 3'h1) ? al_cur_reg[1]
                            : trip_i_reg[2'(job_reg - 3'h2)];

   // segment search over points 2 to 8
   logic [2:0] seg;
   logic       in_seg;
   always_comb
   begin
      seg    = 3'h1;
      in_seg = 1'b0;
      for (int k = 1; k < NPTS - 1; k++)
         if (pt_ok[k + 1] && cur_sel >= pt_cur_reg[k])
         begin
            seg    = 3'(k);
            in_seg = 1'b1;
         end
   end

   logic [2:0] last_ok;
   always_comb
   begin
      last_ok = 3'h1;
      for (int k = 2; k < NPTS; k++)
         if (pt_ok[k])
            last_ok = 3'(k);
   end

   wire [LG_W-1:0] lg_i   = lg2({1'b0, cur_sel});
   wire [LG_W-1:0] lg_ik  = lg2({1'b0, pt_cur_reg[seg]});
   wire [LG_W-1:0] lg_ik1 = lg2({1'b0, pt_cur_reg[3'(seg + 3'h1)]});
   wire [LG_W-1:0] lg_ck  = lg2(pt_cnt_reg[seg]);
   wire [LG_W-1:0] lg_ck1 = lg2(pt_cnt_reg[3'(seg + 3'h1)]);
   wire            beyond = in_seg & (cur_sel >= pt_cur_reg[3'(seg + 3'h1)]);
   wire            below  = cur_sel < pt_cur_reg[1];
   wire            flat   = ~in_seg | beyond | (lg_ik1 <= lg_ik)
                          | (lg_ck <= lg_ck1);
   wire [LG_W-1:0] dlc    = lg_ck - lg_ck1;
   wire [LG_W-1:0] dli    = (lg_i > lg_ik) ? lg_i - lg_ik : '0;
   // base - dlc*dli/den : exponent n times log current ratio
   wire [LG_W-1:0] d_base = below ? lg2(pt_cnt_reg[0])
                          : beyond ? lg_ck1
                          : ~in_seg ? lg2(pt_cnt_reg[last_ok])
                          : lg_ck;
   wire [NUM_W-1:0] d_num = flat ? '0 : dlc * dli;
   wire [LG_W-1:0]  d_den = flat ? 13'h0001 : lg_ik1 - lg_ik;

   // restoring divider step
   wire [LG_W:0] rem_t = {rem_reg[LG_W-1:0], dnum_reg[NUM_W-1]};
   wire          div_ge = rem_t >= {1'b0, den_reg};
   wire [LG_W-1:0] quo = dnum_reg[LG_W-1:0];
   wire [LG_W-1:0] lc_res = (quo > base_reg) ? '0 : base_reg - quo;
   wire [2:0] job_last = mode_clr_reg ? JOB_CLEAR_LAST : JOB_TRIP_LAST;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= BWM_IDLE;
         job_reg   <= 3'h0;
         mode_clr_reg <= 1'b0;
         base_reg  <= '0;
         den_reg   <= 13'h0001;
         dnum_reg  <= '0;
         rem_reg   <= '0;
         step_reg  <= 6'h00;
      end
      else
      begin
         case (state_reg)
            BWM_IDLE:
               if (start)
               begin
                  mode_clr_reg <= clr_pend_reg;
                  job_reg      <= 3'h0;
                  state_reg    <= BWM_SEG;
               end
            BWM_SEG:
            begin
               base_reg  <= d_base;
               den_reg   <= d_den;
               dnum_reg  <= d_num;
               rem_reg   <= '0;
               step_reg  <= DIV_STEPS;
               state_reg <= BWM_DIV;
            end
            BWM_DIV:
            begin
               rem_reg  <= div_ge ? rem_t - {1'b0, den_reg} : rem_t;
               dnum_reg <= {dnum_reg[NUM_W-2:0], div_ge};
               step_reg <= step_reg - 6'h01;
               if (step_reg == 6'h01)
                  state_reg <= BWM_STORE;
            end
            BWM_STORE:
            begin
               job_reg <= job_reg + 3'h1;
               state_reg <= (job_reg == job_last) ? BWM_APPLY : BWM_SEG;
            end
            BWM_APPLY:
               state_reg <= BWM_IDLE;
            default:
               state_reg <= BWM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         for (int j = 0; j < 5; j++)
            lc_reg[j] <= '0;
      else if (state_reg == BWM_STORE)
         lc_reg[job_reg] <= lc_res;
   end

   // counter update, one per alarm point and phase
   genvar gc;
   generate
      for (gc = 0; gc < 6; gc++)
      begin : g_cnt
         localparam int A = gc / 3;
         localparam int P = gc % 3;
         wire [LG_W-1:0]  ldiff = lc_reg[A] - lc_reg[2 + P];
         wire [CNT_W-1:0] wdel  = exp2(ldiff);
         wire             one   = (trip_i_reg[P] < al_cur_reg[A])
                                | (lc_reg[A] <= lc_reg[2 + P]);
         wire [CNT_W-1:0] dec   = one ? 17'h00001
                                : (wdel == '0) ? 17'h00001 : wdel;
         wire [CNT_W-1:0] left  = (dec > cnt_reg[gc]) ? '0
                                : cnt_reg[gc] - dec;
         always_ff @(posedge clk)
         begin
            if (!rst_n)
               cnt_reg[gc] <= '0;
            else if (state_reg == BWM_APPLY)
               cnt_reg[gc] <= mode_clr_reg ? exp2(lc_reg[A]) : left;
         end
      end
   endgenerate

   // smallest of three per alarm point
   function automatic logic [CNT_W-1:0] min3(input logic [CNT_W-1:0] a,
                                             input logic [CNT_W-1:0] b,
                                             input logic [CNT_W-1:0] c);
      logic [CNT_W-1:0] m;
      m = (a < b) ? a : b;
      return (c < m) ? c : m;
   endfunction

   wire [CNT_W-1:0] min_a1 = min3(cnt_reg[0], cnt_reg[1], cnt_reg[2]);
   wire [CNT_W-1:0] min_a2 = min3(cnt_reg[3], cnt_reg[4], cnt_reg[5]);
   wire [1:0] alarm_next = {min_a2 < al_lim_reg[1],
                            min_a1 < al_lim_reg[0]};
   wire [1:0] a_rise = alarm_next & ~alarm_reg;
   wire [1:0] a_fall = ~alarm_next & alarm_reg;
   wire [1:0] log_on  = a_rise & {even_reg[2], even_reg[0]};
   wire [1:0] log_off = a_fall & {even_reg[3], even_reg[1]};
   wire [IRQ_W-1:0] irq_set = {log_off[1], log_on[1], log_off[0],
                               log_on[0], state_reg == BWM_APPLY};
   wire [IRQ_W-1:0] irq_clr = wr_iclr ? pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         alarm_reg    <= 2'b00;
         ev_on_reg    <= 2'b00;
         ev_off_reg   <= 2'b00;
         irq_stat_reg <= '0;
         relay_prev_reg <= 1'b0;
         trip_pend_reg  <= 1'b0;
         clr_pend_reg   <= 1'b0;
         trip_ts_reg    <= '0;
         for (int p = 0; p < 3; p++)
            trip_i_reg[p] <= '0;
      end
      else
      begin
         alarm_reg    <= alarm_next;
         ev_on_reg    <= log_on;
         ev_off_reg   <= log_off;
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         relay_prev_reg <= relay_now;
         trip_pend_reg  <= trip_rise | (trip_pend_reg & ~(start & ~clr_pend_reg));
         clr_pend_reg   <= (wr_ctrl & pwdata[CTRL_CLEAR])
                         | (clr_pend_reg & ~start);
         if (trip_rise)
         begin
            trip_ts_reg   <= time_stamp;
            trip_i_reg[0] <= phase_current_l1;
            trip_i_reg[1] <= phase_current_l2;
            trip_i_reg[2] <= phase_current_l3;
         end
      end
   end

   // settings written by software
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NPTS; p++)
         begin
            pt_cur_reg[p] <= RST_PT_CUR;
            pt_cnt_reg[p] <= RST_PT_CNT;
         end
         cap_reg    <= RST_CAP;
         al_cur_reg[0] <= '0;
         al_cur_reg[1] <= '0;
         al_lim_reg[0] <= RST_LIM;
         al_lim_reg[1] <= RST_LIM;
         sel_reg    <= 2'b00;
         even_reg   <= 4'h0;
         irq_en_reg <= '0;
      end
      else
      begin
         if (wr_pt & ~pt_hi)
            pt_cur_reg[pt_idx] <= pwdata[CUR_W-1:0];
         if (wr_pt & pt_hi)
            pt_cnt_reg[pt_idx] <= pwdata[CNT_W-1:0];
         if (wr_cap)
            cap_reg <= pwdata[CUR_W-1:0];
         if (wr_a1c)
            al_cur_reg[0] <= w_cur;
         if (wr_a1l)
            al_lim_reg[0] <= w_lim;
         if (wr_a2c)
            al_cur_reg[1] <= w_cur;
         if (wr_a2l)
            al_lim_reg[1] <= w_lim;
         if (wr_ctrl)
         begin
            sel_reg  <= pwdata[CTRL_SEL_LO +: 2];
            even_reg <= pwdata[CTRL_EVEN_LO +: 4];
         end
         if (wr_ien)
            irq_en_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // read mux, sampled in the setup phase
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_pt)
         rd_mux = pt_hi ? 32'(pt_cnt_reg[pt_idx]) : 32'(pt_cur_reg[pt_idx]);
      else if (hit_c)
         rd_mux = 32'(cnt_reg[c_idx]);
      else if (paddr >= OFS_TRIP_I && hit_lo)
         rd_mux = 32'(trip_i_reg[t_idx]);
      else
         case (paddr)
            OFS_CTRL:     rd_mux = 32'({busy, even_reg, sel_reg, 2'b00});
            OFS_CAP:      rd_mux = 32'(cap_reg);
            OFS_AL1_CUR:  rd_mux = 32'(al_cur_reg[0]);
            OFS_AL1_LIM:  rd_mux = 32'(al_lim_reg[0]);
            OFS_AL2_CUR:  rd_mux = 32'(al_cur_reg[1]);
            OFS_AL2_LIM:  rd_mux = 32'(al_lim_reg[1]);
            OFS_ALARM:    rd_mux = 32'(alarm_reg);
            OFS_IRQ_STAT: rd_mux = 32'(irq_stat_reg);
            OFS_IRQ_EN:   rd_mux = 32'(irq_en_reg);
            OFS_TRIP_TS:  rd_mux = trip_ts_reg;
            default:      rd_mux = 32'h0000_0000;
         endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata_reg <= '0;
      else if (psel & ~penable)
         prdata_reg <= hit ? rd_mux : 32'h0000_0000;
   end

   assign prdata    = prdata_reg;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit;
   assign alarm_out = alarm_reg;
   assign event_on  = ev_on_reg;
   assign event_off = ev_off_reg;
   assign irq       = |(irq_stat_reg & irq_en_reg);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_trip_seen;
      trip_rise ##1 1'b1;
   endsequence

   a_trip_capture: assert property (s_trip_seen |-> trip_i_reg[0] ==
         $past(phase_current_l1) && trip_ts_reg == $past(time_stamp))
      else $error("trip currents not captured");
   a_pole_three: assert property (trip_rise |=>
         trip_i_reg[1] == $past(phase_current_l2)
         && trip_i_reg[2] == $past(phase_current_l3))
      else $error("pole currents not recorded");
   a_alarm_rise: assert property (alarm_out[0] |->
         $past(min_a1 < al_lim_reg[0]))
      else $error("alarm one without low counter");
   a_alarm_fall: assert property ($fell(alarm_out[1]) |->
         $past(min_a2 >= al_lim_reg[1]))
      else $error("alarm two fell wrongly");
   a_event_gate: assert property (event_on[0] |->
         $past(even_reg[0]) && $rose(alarm_out[0]))
      else $error("ungated alarm event");
   a_off_gate: assert property ($fell(alarm_out[1]) && $past(even_reg[3])
         |-> event_off[1])
      else $error("alarm two off event missing");
   a_clear_load: assert property (state_reg == BWM_APPLY && mode_clr_reg
         |=> cnt_reg[3] == exp2(lc_reg[1]))
      else $error("clear did not reload counter");
   a_sat_zero: assert property (state_reg == BWM_APPLY && !mode_clr_reg
         && cnt_reg[0] == '0 |=> cnt_reg[0] == '0)
      else $error("counter wrapped");
   a_dec_one: assert property (state_reg == BWM_APPLY && !mode_clr_reg
         && trip_i_reg[2] < al_cur_reg[0] && cnt_reg[2] != '0
         |=> cnt_reg[2] == $past(cnt_reg[2]) - 17'h00001)
      else $error("low current step not one");
   a_limit_range: assert property (al_lim_reg[0] >= LIM_MIN
         && al_lim_reg[0] <= LIM_MAX && al_cur_reg[1] <= AL_CUR_MAX)
      else $error("setting out of range");
   a_trip_done: assert property (state_reg == BWM_SEG && !mode_clr_reg
         |-> ##[1:200] state_reg == BWM_APPLY)
      else $error("trip evaluation did not finish");
endmodule  // bwm_breaker_wear_monitor
`default_nettype wire

/* bwm_pkg.sv */
package bwm_pkg;
   localparam int CUR_W    = 16;
   localparam int CNT_W    = 17;
   localparam int LG_W     = 13;
   localparam int NUM_W    = 26;
   localparam int NPTS     = 8;
   localparam int ADDR_W   = 8;
   localparam int NRELAY   = 4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_CAP      = 8'h04;
   localparam logic [7:0] OFS_AL1_CUR  = 8'h08;
   localparam logic [7:0] OFS_AL1_LIM  = 8'h0C;
   localparam logic [7:0] OFS_AL2_CUR  = 8'h10;
   localparam logic [7:0] OFS_AL2_LIM  = 8'h14;
   localparam logic [7:0] OFS_ALARM    = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h24;
   localparam logic [7:0] OFS_TRIP_TS  = 8'h28;
   localparam logic [7:0] OFS_TRIP_I   = 8'h2C;
   localparam logic [7:0] OFS_CNT      = 8'h40;
   localparam logic [7:0] OFS_CURVE    = 8'h80;
   // control register fields
   localparam int CTRL_CLEAR   = 0;
   localparam int CTRL_SEL_LO  = 2;
   localparam int CTRL_EVEN_LO = 4;
   localparam int CTRL_BUSY    = 8;
   // interrupt status bits
   localparam int IRQ_TRIP = 0;
   localparam int IRQ_W    = 5;
   // setting ranges, currents in units of 10 A
   localparam logic [CUR_W-1:0] AL_CUR_MAX = 16'h2710;
   localparam logic [CNT_W-1:0] LIM_MIN    = 17'h00001;
   localparam logic [CNT_W-1:0] LIM_MAX    = 17'h186A0;
   // reset values: every curve point starts unused
   localparam logic [CUR_W-1:0] RST_PT_CUR = 16'hFFFF;
   localparam logic [CNT_W-1:0] RST_PT_CNT = 17'h00001;
   localparam logic [CUR_W-1:0] RST_CAP    = 16'hFFFF;
   localparam logic [CNT_W-1:0] RST_LIM    = 17'h00001;
   localparam logic [5:0]       DIV_STEPS  = 6'h1A;
   localparam logic [2:0]       JOB_CLEAR_LAST = 3'h1;
   localparam logic [2:0]       JOB_TRIP_LAST  = 3'h4;

   typedef enum logic [2:0] {
      BWM_IDLE  = 3'b000,
      BWM_SEG   = 3'b001,
      BWM_DIV   = 3'b011,
      BWM_STORE = 3'b010,
      BWM_APPLY = 3'b110
   } bwm_state_t;
endpackage

/* bwm_trip_source.sv */
`timescale 1ns/1ns
`default_nettype none
module bwm_trip_source
   import bwm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              fire,
   input  wire logic [1:0]        relay_sel,
   input  wire logic [3:0]        hold_len,
   input  wire logic [CUR_W-1:0]  cur_a,
   input  wire logic [CUR_W-1:0]  cur_b,
   input  wire logic [CUR_W-1:0]  cur_c,
   output logic      [CUR_W-1:0]  phase_current_l1,
   output logic      [CUR_W-1:0]  phase_current_l2,
   output logic      [CUR_W-1:0]  phase_current_l3,
   output logic      [NRELAY-1:0] trip_relay
);
   logic [3:0] hold_reg;
   initial
   begin
      hold_reg = 4'h0;
      trip_relay = '0;
      phase_current_l1 = '0;
      phase_current_l2 = '0;
      phase_current_l3 = '0;
   end
   // currents stand while the relay is closed, then flip to their bitwise inverse when it opens
   always @(posedge clk)
   begin
      if (fire)
      begin
         phase_current_l1 <= cur_a;
         phase_current_l2 <= cur_b;
         phase_current_l3 <= cur_c;
         trip_relay <= 4'h1 << relay_sel;
         hold_reg <= hold_len;
      end
      else if (hold_reg != 4'h0)
         hold_reg <= hold_reg - 4'h1;
      else if (trip_relay != '0)
      begin
         trip_relay <= '0;
         phase_current_l1 <= ~phase_current_l1;
         phase_current_l2 <= ~phase_current_l2;
         phase_current_l3 <= ~phase_current_l3;
      end
   end
endmodule // bwm_trip_source
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import bwm_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              psel, penable, pwrite, fire, pready, pslverr, irq, e;
   logic [7:0]        paddr;
   logic [3:0]        hold;
   logic [31:0]       pwdata, prdata, time_stamp, q, ts;
   logic [1:0]        alarm_out, event_on, event_off, rsel;
   logic [CUR_W-1:0]  l1, l2, l3, ca, cb, cc;
   logic [NRELAY-1:0] trip_relay;
   int                err_total = 0;
   int                checked = 0;
   integer            seed = 32'h9d00;
   logic [3:0]        ev_seen = 4'h0;
   always #10 clk = ~clk;
   // sticky record of every event pulse, {off2, off1, on2, on1}
   always @(posedge clk) ev_seen <= ev_seen | {event_off, event_on};
   bwm_breaker_wear_monitor dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phase_current_l1(l1), .phase_current_l2(l2),
      .phase_current_l3(l3), .trip_relay(trip_relay),
      .time_stamp(time_stamp), .alarm_out(alarm_out), .event_on(event_on),
      .event_off(event_off), .irq(irq));
   bwm_trip_source src (.clk(clk), .fire(fire), .relay_sel(rsel),
      .hold_len(hold), .cur_a(ca), .cur_b(cb), .cur_c(cc),
      .phase_current_l1(l1), .phase_current_l2(l2),
      .phase_current_l3(l3), .trip_relay(trip_relay));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         err_total++;
         $display("wrong value t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         err_total++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask
   // wait until the wear engine reports idle
   task automatic settle();
      int n;
      n = 0;
      repeat (6) @(posedge clk);
      do
      begin
         apb(1'b0, OFS_CTRL, 32'h0);
         n++;
      end
      while (q[CTRL_BUSY] !== 1'b0 && n < 100);
      if (n >= 100)
         err_total++;
      repeat (4) @(posedge clk);
   endtask
   task automatic trip(input logic [1:0] r, input logic [15:0] a,
                       input logic [15:0] b, input logic [15:0] c);
      ts = $random(seed);
      time_stamp <= ts;
      hold <= 4'($random(seed));
      ca <= a;
      cb <= b;
      cc <= c;
      rsel <= r;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      settle();
   endtask
   // counter after one trip: ratio of counts, one below the alarm current
   function automatic logic [31:0] left(input int l, input int ca_n,
                                        input int cp_n, input bit below);
      int d;
      d = below ? 1 : ca_n / cp_n;
      if (d < 1)
         d = 1;
      return (d > l) ? 32'h0 : 32'(l - d);
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      results();
   end
   initial
   begin
      {psel, penable, pwrite, fire, rsel, hold} = '0;
      {paddr, pwdata, time_stamp, ca, cb, cc} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk({30'h0, alarm_out}, 32'h3);
      rc(OFS_CAP, 32'hFFFF);
      rc(OFS_CURVE + 8'h38, 32'hFFFF);
      rc(OFS_CURVE + 8'h3C, 32'h1);
      rc(8'h38, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test reset done");
      apb(1'b1, OFS_AL1_CUR, 32'hFFFF);
      rc(OFS_AL1_CUR, 32'h2710);
      apb(1'b1, OFS_AL1_LIM, 32'h0);
      rc(OFS_AL1_LIM, 32'h1);
      apb(1'b1, OFS_AL2_LIM, 32'h3FFFF);
      rc(OFS_AL2_LIM, 32'h186A0);
      $display("test ranges done");
      apb(1'b1, OFS_CURVE + 8'h04, 32'd1024);
      apb(1'b1, OFS_CURVE + 8'h08, 32'd64);
      apb(1'b1, OFS_CURVE + 8'h0C, 32'd1024);
      apb(1'b1, OFS_CURVE + 8'h10, 32'd128);
      apb(1'b1, OFS_CURVE + 8'h14, 32'd256);
      apb(1'b1, OFS_AL1_CUR, 32'd64);
      apb(1'b1, OFS_AL2_CUR, 32'd128);
      apb(1'b1, OFS_AL1_LIM, 32'd1021);
      apb(1'b1, OFS_AL2_LIM, 32'd255);
      apb(1'b1, OFS_IRQ_EN, 32'h1F);
      apb(1'b1, OFS_CTRL, 32'h95);
      settle();
      for (int i = 0; i < 6; i++)
         rc(OFS_CNT + 8'(4 * i), (i < 3) ? 32'd1024 : 32'd256);
      chk({30'h0, alarm_out}, 32'h0);
      rc(OFS_IRQ_STAT, 32'h11);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_CLR, 32'h1F);
      rc(OFS_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({28'h0, ev_seen}, 32'h8);
      $display("test clear done");
      trip(2'h0, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
      rc(OFS_IRQ_STAT, 32'h0);
      rc(OFS_CNT, 32'd1024);
      $display("test unselected relay done");
      trip(2'h1, 16'd128, 16'd32, 16'd48);
      rc(OFS_TRIP_TS, ts);
      rc(OFS_TRIP_I, 32'd128);
      rc(OFS_TRIP_I + 8'h4, 32'd32);
      rc(OFS_TRIP_I + 8'h8, 32'd48);
      rc(OFS_CNT, left(1024, 1024, 256, 0));
      rc(OFS_CNT + 8'h4, left(1024, 1024, 1024, 1));
      rc(OFS_CNT + 8'h8, left(1024, 1024, 1024, 1));
      rc(OFS_CNT + 8'hC, left(256, 256, 256, 0));
      rc(OFS_CNT + 8'h14, left(256, 256, 1024, 1));
      chk({30'h0, alarm_out}, 32'h1);
      rc(OFS_IRQ_STAT, 32'h3);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({28'h0, ev_seen}, 32'h9);
      $display("test weighted trip done");
      apb(1'b1, OFS_CURVE + 8'h14, 32'd1);
      trip(2'h1, 16'd128, 16'd128, 16'd128);
      rc(OFS_CNT, left(1020, 1024, 1, 0));
      rc(OFS_CNT + 8'h10, left(255, 1, 1, 0));
      chk({30'h0, alarm_out}, 32'h3);
      $display("test saturation done");
      apb(1'b1, OFS_CTRL, 32'hFC);
      trip(2'h3, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
      rc(OFS_CNT, 32'h0);
      apb(1'b1, OFS_CTRL, 32'hFD);
      settle();
      rc(OFS_CNT + 8'h8, 32'd1024);
      rc(OFS_CNT + 8'hC, 32'h1);
      chk({30'h0, alarm_out}, 32'h2);
      chk({28'h0, ev_seen}, 32'hD);
      $display("test reload done");
      results();
   end
endmodule // tb
`default_nettype wire
